// file: tb.sv
// Self-checking bench for the two-wire slave block
`timescale 1ns/1ps
module tb;
  import two_wire_slave_pkg::*;
  logic clk, rst_n, read, write, arb_lost, sleep_in, a;
  logic [3:0] address;
  logic [3:0] be;
  logic [31:0] writedata, readdata;
  logic waitrequest, scl_oe_n, sda_oe_n, wake_req, start_issue, irq;
  logic m_scl_oe_n, m_sda_oe_n;
  logic [7:0] v, b;
  logic [7:0] ra [3] = '{8'h54, 8'h55, 8'h55};
  logic [7:0] rw [3] = '{8'h45, 8'h05, 8'h45};
  logic [7:0] rb [3] = '{8'h00, 8'h54, 8'h56};
  wire scl = scl_oe_n & m_scl_oe_n;
  wire sda = sda_oe_n & m_sda_oe_n;
  int fails = 0, checked = 0, tick = 0, starts = 0;
  two_wire_slave i_two_wire_slave (.clk, .rst_n, .address, .read, .write,
    .writedata, .byteenable(be), .readdata, .waitrequest, .scl_in(scl),
    .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(), .sda_oe_n, .arb_lost,
    .sleep_in, .wake_req, .start_issue, .irq);
  twi_master i_twi_master (.scl, .sda, .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Timeout and start pulse count
  always @(posedge clk) begin
    tick <= tick + 1;
    if (start_issue === 1'b1) starts <= starts + 1;
    if (tick == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Avalon access, held until waitrequest is low
  task automatic acc(input logic w, input logic [3:0] ad,
                     input logic [7:0] d);
    @(posedge clk);
    address <= ad;
    writedata <= {24'h0, d};
    if (w) write <= 1'b1;
    else read <= 1'b1;
    // Sample at the rising edge; waitrequest low ends the transfer
    do @(posedge clk); while (waitrequest !== 1'b0);
    v = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] ad, input logic [7:0] e);
    acc(1'b0, ad, 8'h00);
    chk(v, e);
  endtask
  task automatic fl();
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(negedge clk);
  endtask
  // Master sends a byte; check answer and status
  task automatic xb(input logic [7:0] d, input logic k, input logic [7:0] s);
    i_twi_master.send(d, a);
    chk({7'h0, a}, {7'h0, k});
    fl();
    acc(1'b0, OFS_STAT, 8'h00);
    chk(v & 8'hf8, s);
  endtask
  // Master reads a byte; check it and status
  task automatic rx(input logic k, input logic [7:0] e, input logic [7:0] s);
    i_twi_master.recv(k, b);
    chk(b, e);
    fl();
    acc(1'b0, OFS_STAT, 8'h00);
    chk(v & 8'hf8, s);
  endtask
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    be = 4'hf;
    writedata = 32'h0;
    arb_lost = 1'b0;
    sleep_in = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rc(OFS_CTRL, CTRL_RESET);
    rc(OFS_ADDR, ADDR_RESET);
    rc(OFS_DATA, DATA_RESET);
    rc(OFS_STAT, ST_NONE);
    rc(4'h2, 8'h00);
    acc(1'b1, OFS_DATA, 8'h12);
    rc(OFS_CTRL, 8'h08);
    acc(1'b1, OFS_ADDR, 8'h55);
    // Write with the low lane off is dropped
    @(posedge clk) be <= 4'h0;
    acc(1'b1, OFS_ADDR, 8'haa);
    @(posedge clk) be <= 4'hf;
    rc(OFS_ADDR, 8'h55);
    acc(1'b1, OFS_CTRL, 8'h45);
    // Slave receive, last byte refused
    i_twi_master.start();
    xb(8'h54, 1'b0, ST_OWN_ADDRESS_WRITE);
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, OFS_CTRL, 8'hc5);
    xb(8'h3c, 1'b0, ST_DATA_ACK);
    rc(OFS_DATA, 8'h3c);
    acc(1'b1, OFS_CTRL, 8'h85);
    xb(8'h71, 1'b1, ST_DATA_NACK);
    acc(1'b1, OFS_CTRL, 8'hc5);
    i_twi_master.stop();
    // General call, then start request on leaving
    i_twi_master.start();
    xb(GC_ADDR, 1'b0, ST_GCA);
    acc(1'b1, OFS_CTRL, 8'hc5);
    xb(8'h5a, 1'b0, ST_GC_ACK);
    acc(1'b1, OFS_CTRL, 8'h85);
    xb(8'h5b, 1'b1, ST_GC_NACK);
    acc(1'b1, OFS_CTRL, 8'he5);
    i_twi_master.stop();
    repeat (20) @(posedge clk);
    chk(starts[7:0], 8'h01);
    // Refused: call off, ack off, foreign address
    foreach (ra[i]) begin
      acc(1'b1, OFS_ADDR, ra[i]);
      acc(1'b1, OFS_CTRL, rw[i]);
      i_twi_master.start();
      xb(rb[i], 1'b1, ST_NONE);
      i_twi_master.stop();
    end
    // Addressed in sleep, then stop while addressed
    @(posedge clk) sleep_in <= 1'b1;
    i_twi_master.start();
    xb(8'h54, 1'b0, ST_OWN_ADDRESS_WRITE);
    chk({7'h0, wake_req}, 8'h01);
    chk({7'h0, scl_oe_n}, 8'h00);
    @(posedge clk) sleep_in <= 1'b0;
    acc(1'b1, OFS_CTRL, 8'hc5);
    i_twi_master.stop();
    fl();
    rc(OFS_STAT, ST_STOP);
    acc(1'b1, OFS_CTRL, 8'hc5);
    // Slave transmit, master wants more after last
    i_twi_master.start();
    xb(8'h55, 1'b0, ST_OWN_ADDRESS_READ);
    acc(1'b1, OFS_DATA, 8'ha5);
    acc(1'b1, OFS_CTRL, 8'hc5);
    rx(1'b0, 8'ha5, ST_TX_ACK);
    acc(1'b1, OFS_DATA, 8'h3c);
    acc(1'b1, OFS_CTRL, 8'h85);
    rx(1'b0, 8'h3c, ST_TX_LAST);
    acc(1'b1, OFS_CTRL, 8'hc5);
    rx(1'b1, 8'hff, ST_NONE);
    i_twi_master.stop();
    // Lost arbitration, one byte, master refuses
    @(posedge clk) arb_lost <= 1'b1;
    i_twi_master.start();
    xb(8'h55, 1'b0, ST_ARB_OWN_ADDRESS_READ);
    @(posedge clk) arb_lost <= 1'b0;
    acc(1'b1, OFS_DATA, 8'h81);
    acc(1'b1, OFS_CTRL, 8'h85);
    rx(1'b1, 8'h81, ST_TX_NACK);
    // Clear with stop request: unaddressed, stop bit dropped
    acc(1'b1, OFS_CTRL, 8'hd5);
    rc(OFS_CTRL, 8'h45);
    i_twi_master.stop();
    conclude();
  end
endmodule // tb
bind two_wire_slave two_wire_slave_sva i_two_wire_slave_sva (.clk, .rst_n,
  .read, .write, .readdata, .waitrequest, .scl_in, .scl_oe_n, .sda_oe_n,
  .sleep_in, .wake_req, .start_issue, .irq);

// file: twi_master.sv
// Bus master model on the far side of the two-wire link
`timescale 1ns/1ps
module twi_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  // Both lines released at start
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // One bit of 320 ns; waits while the slave stretches
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n = b;
    #80 scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #80 r = sda;
    #80 scl_oe_n = 1'b0;
    #80;
  endtask
  task automatic start();
    sda_oe_n = 1'b1;
    #80 scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #160 sda_oe_n = 1'b0;
    #160 scl_oe_n = 1'b0;
    #80;
  endtask
  task automatic stop();
    sda_oe_n = 1'b0;
    #80 scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #160 sda_oe_n = 1'b1;
    #160;
  endtask
  // Byte out, most significant bit first, then the answer
  task automatic send(input logic [7:0] v, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, ack_n);
  endtask
  task automatic recv(input logic ack_n, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(ack_n, r);
  endtask
endmodule // twi_master

// file: two_wire_slave.sv
// Addressed two-wire slave: receive tail, transmit, Avalon-MM registers
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module two_wire_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic arb_lost,
  input wire logic sleep_in,
  output logic wake_req,
  output logic start_issue,
  output logic irq
);
  import two_wire_slave_pkg::*;

  st_t q; // Registered state
  st_t d; // Next state
  logic scl_rise; // Filtered clock rising edge
  logic scl_fall; // Filtered clock falling edge
  logic start_seen; // Data falls while clock high
  logic stop_seen; // Data rises while clock high
  logic own_hit; // Own address matches
  logic gc_hit; // General call accepted
  logic wr_ok; // Write taken this edge
  logic rd_go; // Read request first cycle

  // Line events from second and third sync stages only
  // Third stage only delays the second, for edge finding
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  assign start_seen = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
  assign stop_seen = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];

  // Address compare on the shifted byte
  assign own_hit = (q.sh[7:1] == q.osa[7:1]);
  assign gc_hit = (q.sh[7:1] == GC_ADDR[7:1]) & q.osa[0];

  // Bus handshake: one wait cycle for every access
  // A write lands at the edge that ends the cycle after its wait cycle
  assign wr_ok = write & q.bus_ack & byteenable[0];
  assign rd_go = read & ~q.bus_ack;
  assign waitrequest = (read | write) & ~q.bus_ack;
  assign readdata = q.rdata;

  // Open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // Stretching lets software pace the bus byte by byte
  // Hold clock low while software owns the event
  assign scl_oe_n = ~(q.state == S_WAIT);
  // Acknowledge or a zero data bit pulls data low
  always_comb begin
    sda_oe_n = 1'b1;
    if ((q.state == S_AACK || q.state == S_RACK) && q.drive) begin
      sda_oe_n = 1'b0;
    end else if (q.state == S_TX && !q.sh[7]) begin
      sda_oe_n = 1'b0;
    end
  end

  // Interrupt and wake are plain levels of the flag
  assign irq = q.ctrl[CTL_FLAG] & q.ctrl[CTL_IE];
  assign wake_req = sleep_in & q.ctrl[CTL_FLAG] & q.addressed;
  assign start_issue = q.start_issue;

  // Next-state logic: bus access first, then line events
  // Later assignments below override earlier ones
  always_comb begin
    d = q;
    // Start strobe defaults low, set below for one cycle
    d.start_issue = 1'b0;
    // Synchronisers, stage 1 feeds only stage 2
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    d.bus_ack = (read | write) & ~q.bus_ack;

    // Read data captured in the wait cycle
    // Unmapped offsets read as zero
    if (rd_go) begin
      unique case (address)
        OFS_ADDR: d.rdata = {24'h000000, q.osa};
        OFS_CTRL: d.rdata = {24'h000000, q.ctrl};
        OFS_STAT: begin
          // Prescaler bits always read zero
          d.rdata = {24'h000000,
            q.ctrl[CTL_FLAG] ? q.status : ST_NONE};
        end
        OFS_DATA: d.rdata = {24'h000000, q.data};
        default: d.rdata = 32'h00000000;
      endcase
    end

    // Register writes
    // Writes with the low byte lane off are dropped
    if (wr_ok) begin
      unique case (address)
        OFS_ADDR: d.osa = writedata[7:0];
        OFS_CTRL: begin
          // Flag is cleared only by writing one to it
          d.ctrl = {q.ctrl[CTL_FLAG] & ~writedata[CTL_FLAG],
            writedata[6:4], q.ctrl[CTL_WC], writedata[2:0]};
          if (q.ctrl[CTL_FLAG] && writedata[CTL_FLAG]) begin
            if (writedata[CTL_STO]) begin
              // Recovery: release lines, drop stop bit
              d.state = S_IDLE;
              d.addressed = 1'b0;
              d.ctrl[CTL_STO] = 1'b0;
            end else if (q.state == S_WAIT) begin
              d.state = q.resume;
              if (q.resume == S_TX) begin
                // Load byte, note whether it is the last
                d.sh = q.data;
                d.cnt = 4'h0;
                d.last = ~writedata[CTL_ACK];
              end else if (q.resume == S_RX) begin
                d.cnt = 4'h0;
              end else begin
                d.addressed = 1'b0;
              end
            end
          end
        end
        OFS_DATA: begin
          // Data write with flag low is a collision
          if (q.ctrl[CTL_FLAG]) begin
            d.data = writedata[7:0];
            d.ctrl[CTL_WC] = 1'b0;
          end else begin
            d.ctrl[CTL_WC] = 1'b1;
          end
        end
        default: d.data = q.data;
      endcase
    end

    // Pending start goes out once the bus is free
    if (q.ctrl[CTL_STA] && q.state == S_IDLE && !q.busy &&
        !q.ctrl[CTL_FLAG]) begin
      d.start_issue = 1'b1;
      d.ctrl[CTL_STA] = 1'b0;
    end

    // Line events; a flag set wins over a clear
    // Start and stop take priority over bit handling
    if (start_seen || stop_seen) begin
      d.busy = start_seen;
      if (q.addressed) begin
        d.status = ST_STOP;
        d.ctrl[CTL_FLAG] = 1'b1;
        d.addressed = 1'b0;
      end
      d.state = start_seen ? S_ADDR : S_IDLE;
      d.cnt = 4'h0;
      d.drive = 1'b0;
    end else begin
      unique case (q.state)
        S_IDLE: d.drive = 1'b0;
        S_ADDR, S_RX: begin
          // Sample on rise, decide acknowledge after eighth bit
          if (scl_rise && q.cnt != BYTE_BITS) begin
            d.sh = {q.sh[6:0], q.sda_s[1]};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == BYTE_BITS) begin
            if (q.state == S_RX) begin
              d.state = S_RACK;
              d.drive = q.ctrl[CTL_ACK];
            end else if (q.ctrl[CTL_EN] && q.ctrl[CTL_ACK] &&
                (own_hit || gc_hit)) begin
              d.state = S_AACK;
              d.drive = 1'b1;
              d.gc = ~own_hit;
            end else begin
              d.state = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            // Address taken: report and stretch
            d.drive = 1'b0;
            d.ctrl[CTL_FLAG] = 1'b1;
            d.addressed = 1'b1;
            d.state = S_WAIT;
            if (q.sh[0] && !q.gc) begin
              d.resume = S_TX;
              d.status = arb_lost ? ST_ARB_OWN_ADDRESS_READ : ST_OWN_ADDRESS_READ;
            end else begin
              d.resume = S_RX;
              if (q.gc) begin
                d.status = arb_lost ? ST_ARB_GCA : ST_GCA;
              end else begin
                d.status = arb_lost ? ST_ARB_OWN_ADDRESS_WRITE : ST_OWN_ADDRESS_WRITE;
              end
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            // Byte in, acknowledge done
            d.drive = 1'b0;
            d.data = q.sh;
            d.ctrl[CTL_FLAG] = 1'b1;
            d.state = S_WAIT;
            d.resume = q.drive ? S_RX : S_IDLE;
            if (q.gc) begin
              d.status = q.drive ? ST_GC_ACK : ST_GC_NACK;
            end else begin
              d.status = q.drive ? ST_DATA_ACK : ST_DATA_NACK;
            end
          end
        end
        S_TX: begin
          // Shift out on each falling clock
          // Bit seven stands on the line once the clock is freed
          if (scl_fall) begin
            if (q.cnt == LAST_TX_BIT) begin
              d.state = S_TACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b1};
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        S_TACK: begin
          if (scl_rise) begin
            d.mack = ~q.sda_s[1];
          end else if (scl_fall) begin
            d.ctrl[CTL_FLAG] = 1'b1;
            d.state = S_WAIT;
            if (!q.mack) begin
              d.status = ST_TX_NACK;
              d.resume = S_IDLE;
            end else if (q.last) begin
              d.status = ST_TX_LAST;
              d.resume = S_IDLE;
            end else begin
              d.status = ST_TX_ACK;
              d.resume = S_TX;
            end
          end
        end
        S_WAIT: d.drive = 1'b0;
      endcase
    end

    // Disabled interface leaves the bus alone
    // Also frees a stretched clock line
    if (!d.ctrl[CTL_EN]) begin
      d.state = S_IDLE;
      d.addressed = 1'b0;
    end
  end

  // State register
  // Idle-high line stages after reset: no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{scl_s: 3'h7, sda_s: 3'h7, state: S_IDLE, resume: S_IDLE,
        cnt: 4'h0, sh: 8'hff, drive: 1'b0, gc: 1'b0, last: 1'b0,
        mack: 1'b0, addressed: 1'b0, busy: 1'b0, osa: ADDR_RESET,
        ctrl: CTRL_RESET, status: ST_NONE, data: DATA_RESET,
        bus_ack: 1'b0, rdata: 32'h00000000, start_issue: 1'b0};
    end else begin
      q <= d;
    end
  end
endmodule // two_wire_slave

// file: two_wire_slave_pkg.sv
// Constants, states and the state record of the two-wire slave block
package two_wire_slave_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] OFS_ADDR = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hc;
  // Field positions in bus_control
  localparam int unsigned CTL_FLAG = 7;
  localparam int unsigned CTL_ACK = 6;
  localparam int unsigned CTL_STA = 5;
  localparam int unsigned CTL_STO = 4;
  localparam int unsigned CTL_WC = 3;
  localparam int unsigned CTL_EN = 2;
  localparam int unsigned CTL_IE = 0;
  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;
  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // Status codes, prescaler bits zero
  localparam logic [7:0] ST_OWN_ADDRESS_WRITE = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_ADDRESS_WRITE = 8'h68;
  localparam logic [7:0] ST_GCA = 8'h70;
  localparam logic [7:0] ST_ARB_GCA = 8'h78;
  localparam logic [7:0] ST_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_ACK = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [7:0] ST_STOP = 8'ha0;
  localparam logic [7:0] ST_OWN_ADDRESS_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_OWN_ADDRESS_READ = 8'hb0;
  localparam logic [7:0] ST_TX_ACK = 8'hb8;
  localparam logic [7:0] ST_TX_NACK = 8'hc0;
  localparam logic [7:0] ST_TX_LAST = 8'hc8;
  localparam logic [7:0] ST_NONE = 8'hf8;
  localparam logic [7:0] GC_ADDR = 8'h00;
  // Bus engine states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK, S_WAIT
  } eng_t;
  // Whole state of the block
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    eng_t state;
    eng_t resume;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic drive;
    logic gc;
    logic last;
    logic mack;
    logic addressed;
    logic busy;
    logic [7:0] osa;
    logic [7:0] ctrl;
    logic [7:0] status;
    logic [7:0] data;
    logic bus_ack;
    logic [31:0] rdata;
    logic start_issue;
  } st_t;
endpackage

// file: two_wire_slave_sva.sv
// Port-level assertions for the two-wire slave block
`timescale 1ns/1ps
module two_wire_slave_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic sleep_in,
  input wire logic wake_req,
  input wire logic start_issue,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // One wait state on every access
  a_wait_first: assert property ($rose(read | write) |-> waitrequest)
    else $error("first request cycle not stalled");
  a_wait_once: assert property ((read | write) & waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  a_read_upper: assert property (read & !waitrequest |->
    readdata[31:8] == 24'h0) else $error("upper read bits not zero");
  // Start request is a single pulse
  a_start_pulse: assert property (start_issue |=> !start_issue)
    else $error("start pulse too long");
  // Clock held until software clears the flag or the enable bit
  a_hold_clear: assert property ($rose(scl_oe_n) |->
    $past(write) || $past(write, 2)) else $error("clock freed without write");
  a_irq_fall: assert property ($fell(irq) |->
    $past(write) || $past(write, 2)) else $error("irq dropped unprompted");
  // Data line moves only while the clock is low
  a_sda_change: assert property ($changed(sda_oe_n) |->
    !$past(scl_in)) else $error("data moved with clock high");
  // Wake request only when asleep, with the clock held
  a_wake_sleep: assert property (wake_req |-> sleep_in)
    else $error("wake request while awake");
  a_wake_hold: assert property (wake_req |-> !scl_oe_n)
    else $error("clock not held during wake");
  a_wake_stretch: assert property (sleep_in & !scl_oe_n |-> wake_req)
    else $error("clock held asleep without wake request");
  c_flag: cover property ($rose(irq));
  c_start: cover property (start_issue);
  c_wake: cover property (wake_req);
endmodule // two_wire_slave_sva
